// file: psr_map.vh
`ifndef PSR_MAP_VH
`define PSR_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define PSR_CTRL_OFS      4'h0
`define PSR_RXDATA_OFS    4'h4
`define PSR_STATUS_OFS    4'h8
`define PSR_IRQ_STAT_OFS  4'hc
`define PSR_IRQ_MASK_OFS  5'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PSR_CTRL_EN_BIT   0
`define PSR_CTRL_DIR_BIT  1
`define PSR_CTRL_CLK_BIT  2
`define PSR_CTRL_DAT_BIT  3
`define PSR_CTRL_RESET    4'h0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define PSR_ST_RDY_BIT    0
`define PSR_ST_PERR_BIT   1
`define PSR_ST_FERR_BIT   2
`define PSR_ST_BUSY_BIT   3
`define PSR_IRQ_RDY_BIT   3
`define PSR_IRQ_ERR_BIT   4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSR_CLK_NS        10
`define PSR_REL_NS        1000
`define PSR_REL_CYC       ((`PSR_REL_NS) / (`PSR_CLK_NS))
`define PSR_RDY_NS        1600
`define PSR_RDY_CYC       ((`PSR_RDY_NS) / (`PSR_CLK_NS))
`define PSR_CLR_NS        500
`define PSR_CLR_CYC       ((`PSR_CLR_NS) / (`PSR_CLK_NS))
`define PSR_FRAME_US      2002
`define PSR_FRAME_CYC     ((`PSR_FRAME_US) * 1000 / (`PSR_CLK_NS))
`define PSR_FRAME_BITS    11

`endif

// file: psr_sync.v
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Three-stage input synchroniser, change accepted when 2nd and 3rd agree
// ----------------------------------------------------------------
module psr_sync (
	input  wire clk_i,    // System clock
	input  wire rst_i,    // Async reset, active high
	input  wire async_i,  // Line from outside the domain
	output reg  level_o   // Filtered level
);
	reg s1;
	reg s2;
	reg s3;

	// First stage feeds only the second; idle line is high
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1      <= 1'b1;
			s2      <= 1'b1;
			s3      <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_o <= s3;
		end
	end
endmodule

// file: psr_avalon.v
`timescale 1ns/1ns
`include "psr_map.vh"
// ----------------------------------------------------------------
// Avalon-MM slave front end: one wait cycle on every access
// ----------------------------------------------------------------
module psr_avalon (
	input  wire        clk_i,        // System clock
	input  wire        rst_i,        // Async reset, active high
	input  wire        read_i,       // Bus read
	input  wire        write_i,      // Bus write
	output reg         waitrequest_o,// Bus stall
	output wire        rd_done_o,    // Read completes this edge
	output wire        wr_done_o     // Write completes this edge
);
	// Stall the first cycle of each request, then let it go
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			waitrequest_o <= 1'b1;
		else if ((read_i || write_i) && waitrequest_o)
			waitrequest_o <= 1'b0;
		else
			waitrequest_o <= 1'b1;
	end

	assign rd_done_o = read_i && !waitrequest_o;
	assign wr_done_o = write_i && !waitrequest_o;
endmodule

// file: psr_receiver.v
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "psr_map.vh"
module psr_receiver #(
	parameter FRAME_CYC = `PSR_FRAME_CYC   // Frame watchdog, shortenable
) (
	input  wire        clk_i,          // System clock 100 MHz
	input  wire        rst_i,          // Async reset, active high
	input  wire [4:0]  address_i,      // Avalon byte address
	input  wire        read_i,         // Avalon read
	input  wire        write_i,        // Avalon write
	input  wire [31:0] writedata_i,    // Avalon write data
	input  wire [3:0]  byteenable_i,   // Avalon byte enables
	output reg  [31:0] readdata_o,     // Avalon read data
	output wire        waitrequest_o,  // Avalon stall (from flop)
	output reg         irq_o,          // Level interrupt
	input  wire        link_clk_i,     // Link clock line in
	output reg         link_clk_o,     // Link clock drive level
	output reg         link_clk_oe_o,  // Link clock drive enable
	input  wire        link_dat_i,     // Link data line in
	output reg         link_dat_o,     // Link data drive level
	output reg         link_dat_oe_o   // Link data drive enable
);
	// ----------------------------------------------------------------
	// Local state
	// ----------------------------------------------------------------
	// Register map, one word per offset, only the low bits are used:
	//   control      - enable, direction, clock and data override levels
	//   receive data - last byte taken off the link; reading it frees the link
	//   status       - ready, parity error, stop error, clock held
	//   irq status   - byte ready and error, write one to clear
	//   irq mask     - same layout as irq status
	// Every access costs one wait cycle, so the read data can be taken
	// from a flop without a combinational path from the address.
	//
	// The link is never buffered: one byte waits in the receive register
	// and the clock line is held low until software takes it. A slow
	// reader therefore slows the peripheral instead of losing bytes.
	//
	// A frame with a bad parity or stop bit is still stored and flagged;
	// software decides whether to drop it.
	localparam ST_OFF   = 2'h0;
	localparam ST_RECV  = 2'h1;
	localparam ST_HOLD  = 2'h2;
	localparam [31:0] FRAME_MAX = FRAME_CYC;

	reg  [3:0]  ctrl;
	reg  [7:0]  rx_byte;
	reg         rdy;
	reg         perr;
	reg         ferr;
	reg  [4:0]  irq_stat;
	reg  [4:0]  irq_mask;
	reg  [1:0]  state;
	reg  [3:0]  bit_cnt;
	reg  [10:0] shreg;
	reg  [31:0] frame_cnt;
	reg         clk_prev;
	reg         ready_set;
	reg         err_set;
	wire        clk_s;
	wire        dat_s;
	wire        rd_done;
	wire        wr_done;
	wire        fall;
	wire        en;
	wire        dir_tx;
	wire [10:0] frame;
	wire        wr_ctrl;
	wire        rd_rx;
	wire        wr_stat;
	wire        wr_mask;

	// ----------------------------------------------------------------
	// Pin synchronisers and bus front end
	// ----------------------------------------------------------------
	psr_sync u_sync_clk (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (link_clk_i),
		.level_o (clk_s)
	);

	psr_sync u_sync_dat (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (link_dat_i),
		.level_o (dat_s)
	);

	psr_avalon u_bus (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.read_i        (read_i),
		.write_i       (write_i),
		.waitrequest_o (waitrequest_o),
		.rd_done_o     (rd_done),
		.wr_done_o     (wr_done)
	);

	assign en      = ctrl[`PSR_CTRL_EN_BIT];
	assign dir_tx  = ctrl[`PSR_CTRL_DIR_BIT];
	assign wr_ctrl = wr_done && (address_i == {1'b0, `PSR_CTRL_OFS}) && byteenable_i[0];
	assign rd_rx   = rd_done && (address_i == {1'b0, `PSR_RXDATA_OFS});
	assign wr_stat = wr_done && (address_i == {1'b0, `PSR_IRQ_STAT_OFS}) && byteenable_i[0];
	assign wr_mask = wr_done && (address_i == `PSR_IRQ_MASK_OFS) && byteenable_i[0];

	// ----------------------------------------------------------------
	// Edge detect on the filtered link clock
	// ----------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			clk_prev <= 1'b1;
		else
			clk_prev <= clk_s;
	end

	assign fall  = clk_prev && !clk_s;
	assign frame = {dat_s, shreg[10:1]};     // Word as it stands after the last bit

	// ----------------------------------------------------------------
	// Receive state machine
	// ----------------------------------------------------------------
	// Bits shift in from the top so the start bit ends in bit 0
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state     <= ST_OFF;
			bit_cnt   <= 4'h0;
			shreg     <= 11'h000;
			frame_cnt <= 32'h0;
			rx_byte   <= 8'h00;
			perr      <= 1'b0;
			ferr      <= 1'b0;
			ready_set <= 1'b0;
			err_set   <= 1'b0;
		end else begin
			ready_set <= 1'b0;
			err_set   <= 1'b0;
			case (state)
			ST_OFF: begin
				bit_cnt   <= 4'h0;
				frame_cnt <= 32'h0;
				if (en && !dir_tx)
					state <= ST_RECV;
			end
			ST_RECV: begin
				if (!en || dir_tx) begin
					state <= ST_OFF;
				end else if (fall) begin
					shreg     <= frame;
					frame_cnt <= 32'h0;
					if (bit_cnt == 4'h0 && dat_s) begin
						// A high start bit is noise; stay idle
						bit_cnt <= 4'h0;
					end else if (bit_cnt == 4'ha) begin
						// Eleventh edge: latch byte
						bit_cnt   <= 4'h0;
						rx_byte   <= frame[8:1];
						perr      <= ~(^frame[9:1]);
						ferr      <= ~frame[10];
						ready_set <= 1'b1;
						err_set   <= ~(^frame[9:1]) | ~frame[10];
						state     <= ST_HOLD;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end else if (bit_cnt != 4'h0) begin
					// Stalled peripheral: drop the partial frame
					if (frame_cnt >= FRAME_MAX) begin
						bit_cnt   <= 4'h0;
						frame_cnt <= 32'h0;
					end else begin
						frame_cnt <= frame_cnt + 32'h1;
					end
				end
			end
			ST_HOLD: begin
				// Link stays inhibited until the host takes the byte
				if (!en || dir_tx)
					state <= ST_OFF;
				else if (rd_rx)
					state <= ST_RECV;
			end
			default: state <= ST_OFF;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Ready flag: set wins over the read that clears it
	// ----------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			rdy <= 1'b0;
		else if (ready_set)
			rdy <= 1'b1;
		else if (rd_rx)
			rdy <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Line drivers, registered so every pin comes from a flop
	// ----------------------------------------------------------------
	// Disabled: drive override levels; receive: float; hold: clock low
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_clk_o    <= 1'b1;
			link_clk_oe_o <= 1'b0;
			link_dat_o    <= 1'b1;
			link_dat_oe_o <= 1'b0;
		end else if (!en) begin
			link_clk_o    <= ctrl[`PSR_CTRL_CLK_BIT];
			link_clk_oe_o <= 1'b1;
			link_dat_o    <= ctrl[`PSR_CTRL_DAT_BIT];
			link_dat_oe_o <= 1'b1;
		end else if (state == ST_HOLD || ready_set) begin
			link_clk_o    <= 1'b0;
			link_clk_oe_o <= 1'b1;
			link_dat_o    <= 1'b1;
			link_dat_oe_o <= 1'b0;
		end else if (!dir_tx) begin
			link_clk_o    <= 1'b1;
			link_clk_oe_o <= 1'b0;
			link_dat_o    <= 1'b1;
			link_dat_oe_o <= 1'b0;
		end else begin
			// Transmit direction belongs to another block; keep lines free
			link_clk_o    <= 1'b1;
			link_clk_oe_o <= 1'b0;
			link_dat_o    <= 1'b1;
			link_dat_oe_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control, interrupt status and mask registers
	// ----------------------------------------------------------------
	// Hardware set wins over a write-one clear in the same cycle
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl     <= `PSR_CTRL_RESET;
			irq_stat <= 5'h00;
			irq_mask <= 5'h00;
		end else begin
			if (wr_ctrl)
				ctrl <= writedata_i[3:0];
			if (wr_mask)
				irq_mask <= writedata_i[4:0];
			irq_stat[`PSR_IRQ_RDY_BIT] <= ready_set |
				(irq_stat[`PSR_IRQ_RDY_BIT] &
				 ~(wr_stat & writedata_i[`PSR_IRQ_RDY_BIT]));
			irq_stat[`PSR_IRQ_ERR_BIT] <= err_set |
				(irq_stat[`PSR_IRQ_ERR_BIT] &
				 ~(wr_stat & writedata_i[`PSR_IRQ_ERR_BIT]));
			irq_stat[2:0] <= 3'h0;
		end
	end

	// Level interrupt from a flop, one cycle behind the status bits
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_stat & irq_mask);
	end

	// ----------------------------------------------------------------
	// Read data, captured while the access is stalled
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero and writes to them are dropped
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			readdata_o <= 32'h0;
		end else if (read_i) begin
			case (address_i)
			{1'b0, `PSR_CTRL_OFS}:     readdata_o <= {28'h0, ctrl};
			{1'b0, `PSR_RXDATA_OFS}:   readdata_o <= {24'h0, rx_byte};
			{1'b0, `PSR_STATUS_OFS}:   readdata_o <= {28'h0, (state == ST_HOLD), ferr, perr, rdy};
			{1'b0, `PSR_IRQ_STAT_OFS}: readdata_o <= {27'h0, irq_stat};
			`PSR_IRQ_MASK_OFS:         readdata_o <= {27'h0, irq_mask};
			default:                   readdata_o <= 32'h0;
			endcase
		end
	end
endmodule

// file: psr_receiver_sva.sv
`timescale 1ns/1ns
module psr_receiver_sva #(
	parameter FRAME_CYC = 5000 // Frame watchdog
) (
	input wire        clk_i,         // Clock
	input wire        rst_i,         // Reset
	input wire [4:0]  address_i,     // Address
	input wire        read_i,        // Read
	input wire        write_i,       // Write
	input wire [31:0] writedata_i,   // Write data
	input wire [3:0]  byteenable_i,  // Lanes
	input wire [31:0] readdata_o,    // Read data
	input wire        waitrequest_o, // Stall
	input wire        irq_o,         // Interrupt
	input wire        link_clk_i,    // Clock line
	input wire        link_clk_o,    // Clock level
	input wire        link_clk_oe_o, // Clock enable
	input wire        link_dat_i,    // Data line
	input wire        link_dat_o,    // Data level
	input wire        link_dat_oe_o  // Data enable
);
	wire       acc_w  = write_i && !waitrequest_o && byteenable_i[0];
	wire       wr_ctl = acc_w && address_i == 5'h00;
	wire       rd_rx  = read_i && !waitrequest_o && address_i == 5'h04;
	reg        en;
	reg        lc_q;
	reg  [1:0] msk;
	reg  [3:0] nf;
	wire       fall   = lc_q && !link_clk_i;
	// Mirror enable and mask; count link clock falls of the frame in flight
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en <= 1'b0;
			lc_q <= 1'b1;
			msk <= 2'b00;
			nf <= 4'h0;
		end else begin
			lc_q <= link_clk_i;
			if (wr_ctl)
				en <= writedata_i[0] && !writedata_i[1];
			if (acc_w && address_i == 5'h10)
				msk <= writedata_i[4:3];
			if (link_clk_oe_o || !en)
				nf <= 4'h0;
			else if (fall)
				nf <= nf + 4'h1;
		end
	end
	// --------
	// Assertions
	// --------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_float_en: assert property (
		wr_ctl && writedata_i[1:0] == 2'b01 |-> ##[1:100] !link_clk_oe_o && !link_dat_oe_o)
		else $error("lines not floated");
	chk_ovr_drive: assert property (
		wr_ctl && !writedata_i[0] |-> ##3 link_clk_oe_o && link_dat_oe_o
		&& link_clk_o == $past(writedata_i[2], 3) && link_dat_o == $past(writedata_i[3], 3))
		else $error("override not driven");
	chk_hold_frame: assert property (
		en && fall && nf == 4'd10 |-> ##[1:160] link_clk_oe_o && !link_clk_o)
		else $error("frame end not flagged");
	chk_hold_low: assert property (
		en && link_clk_oe_o && !link_clk_o && !rd_rx && !wr_ctl && !$past(rd_rx || wr_ctl)
		|=> link_clk_oe_o && !link_clk_o)
		else $error("clock hold dropped");
	chk_rel_read: assert property (
		en && rd_rx && link_clk_oe_o |-> ##[1:3] !link_clk_oe_o)
		else $error("clock not released");
	chk_irq_set: assert property (
		en && msk[0] && $rose(link_clk_oe_o) |-> ##[0:3] irq_o)
		else $error("no interrupt");
	chk_irq_clr: assert property (
		acc_w && address_i == 5'h0c && writedata_i[4:3] == 2'b11 && !link_clk_oe_o |-> ##3 !irq_o)
		else $error("interrupt not cleared");
	chk_irq_mask: assert property (
		msk == 2'b00 && $past(msk) == 2'b00 |-> !irq_o)
		else $error("masked interrupt seen");
endmodule
bind psr_receiver psr_receiver_sva #(.FRAME_CYC(FRAME_CYC)) u_psr_receiver_sva (
	.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
	.write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
	.readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
	.link_clk_i(link_clk_i), .link_clk_o(link_clk_o), .link_clk_oe_o(link_clk_oe_o),
	.link_dat_i(link_dat_i), .link_dat_o(link_dat_o), .link_dat_oe_o(link_dat_oe_o));

// file: psr_periph.sv
`timescale 1ns/1ns
// Pointing device: pulls clock and data low, never drives high
module psr_periph (
	input  wire clk_line_i, // Resolved clock line
	output reg  clk_low_o,  // Pull clock low
	output reg  dat_low_o   // Pull data low
);
	initial begin
		clk_low_o = 1'b0;
		dat_low_o = 1'b0;
	end
	// One frame; a clock held low by the host stalls the next bit
	task send(input [7:0] b, input bad, input integer half);
		reg [10:0] f;
		integer    i;
		begin
			f = {1'b1, ~^b ^ bad, b, 1'b0};
			#1; // Keep edges off the system clock edge
			for (i = 0; i < 11; i = i + 1) begin
				if (clk_line_i !== 1'b1) begin
					wait (clk_line_i === 1'b1);
					#1;
				end
				dat_low_o = !f[i];
				#(half / 2);
				clk_low_o = 1'b1;
				#(half);
				clk_low_o = 1'b0;
				#(half / 2);
			end
			dat_low_o = 1'b0; // Released: pull-up takes it high
		end
	endtask
endmodule

// file: psr_receiver_tb.sv
`timescale 1ns/1ns
module psr_receiver_tb;
	reg         clk_i = 0, rst_i = 1, read_i = 0, write_i = 0;
	reg  [4:0]  address_i = 0;
	reg  [31:0] writedata_i = 0, rd;
	reg  [3:0]  byteenable_i = 4'hf;
	reg  [7:0]  b;
	wire [31:0] readdata_o;
	wire        waitrequest_o, irq_o, clk_low, dat_low;
	wire        link_clk_o, link_clk_oe_o, link_dat_o, link_dat_oe_o;
	integer     n_fail = 0, n_compared = 0, cyc = 0, seed = 32'h7700, i;
	// Open-drain lines with pull-ups
	wire lclk = !(clk_low || (link_clk_oe_o && !link_clk_o));
	wire ldat = !(dat_low || (link_dat_oe_o && !link_dat_o));
	always #5 clk_i = !clk_i;
	psr_receiver #(.FRAME_CYC(5000)) u_psr_receiver (.clk_i(clk_i), .rst_i(rst_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .irq_o(irq_o), .link_clk_i(lclk),
		.link_clk_o(link_clk_o), .link_clk_oe_o(link_clk_oe_o), .link_dat_i(ldat),
		.link_dat_o(link_dat_o), .link_dat_oe_o(link_dat_oe_o));
	psr_periph u_psr_periph (.clk_line_i(lclk), .clk_low_o(clk_low), .dat_low_o(dat_low));
	// --------
	// Checks and bus cycles
	// --------
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("FAIL %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Request held until waitrequest is seen low; read data taken at that edge
	task bus(input wr, input [4:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			address_i <= a;
			writedata_i <= d;
			read_i <= !wr;
			write_i <= wr;
			@(posedge clk_i);
			while (waitrequest_o !== 1'b0) @(posedge clk_i);
			rd = readdata_o;
			read_i <= 1'b0;
			write_i <= 1'b0;
		end
	endtask
	// One frame in, read it out, clear the interrupt
	task frame(input [7:0] v, input bad, input integer half, input irq_exp);
		integer n;
		begin
			u_psr_periph.send(v, bad, half);
			n = 0;
			while (link_clk_oe_o !== 1'b1 && n < 400) begin
				n = n + 1;
				@(posedge clk_i);
			end
			repeat (3) @(posedge clk_i);
			chk(lclk, 1'b0);
			chk(irq_o, irq_exp);
			bus(1'b0, 5'h08, 0);
			chk(rd[3:0], {2'b10, bad, 1'b1});
			bus(1'b0, 5'h04, 0);
			chk(rd[7:0], v);
			repeat (3) @(posedge clk_i);
			chk(lclk, 1'b1);
			bus(1'b0, 5'h08, 0);
			chk(rd[0], 1'b0);
			bus(1'b1, 5'h0c, 32'h18);
			repeat (3) @(posedge clk_i);
			chk(irq_o, 1'b0);
		end
	endtask
	task give_verdict;
		begin
			$display("compared %0d failed %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Cut a hang short; the run needs well under this
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			give_verdict;
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, 5'h00, 32'hc);
		repeat (3) @(posedge clk_i);
		chk({link_clk_oe_o, link_dat_oe_o, lclk, ldat}, 4'hf);
		bus(1'b1, 5'h00, 32'h0);
		repeat (3) @(posedge clk_i);
		chk({link_clk_oe_o, link_dat_oe_o, lclk, ldat}, 4'hc);
		bus(1'b0, 5'h14, 0);
		chk(rd, 32'h0); // Unmapped reads zero
		bus(1'b1, 5'h10, 32'h18);
		bus(1'b0, 5'h10, 0);
		chk(rd[4:0], 5'h18);
		bus(1'b1, 5'h00, 32'h1);
		repeat (100) @(posedge clk_i);
		chk({link_clk_oe_o, link_dat_oe_o, lclk, ldat}, 4'h3);
		frame(8'h00, 1'b0, 80, 1'b1);
		frame(8'hff, 1'b1, 80, 1'b1);
		for (i = 0; i < 8; i = i + 1) begin
			b = $random(seed);
			frame(b, i[0], 80, 1'b1);
		end
		bus(1'b1, 5'h10, 32'h0);
		frame(8'h5a, 1'b1, 80, 1'b0);
		give_verdict;
	end
endmodule
